// ---- src/eus_top.sv ----
/*
 Serial port extensions: address detect, wake on edge, break send, sync master.
 Assumes one 200 MHz clock, a register port with read data one cycle later,
 and SLEEP high while the device sleeps.
*/
// Contract
// - During sleep the baud timing and byte reception stand still.
// - Wake enable disables normal reception; port idles watching the line.
// - A wake event is a falling edge of the receive line.
// - A wake event sets the receive flag, also while sleeping.
// - Reading the receive buffer clears the receive flag.
// - First rising edge after the wake event clears wake enable.
// - Break is start bit, twelve zero bits, stop bit.
// - Break request with transmit enable at shifter load sends zeros, ignoring data.
// - Break request clears itself after the break stop bit.
// - Shift register empty shows active or idle during a break too.
// - Wake reception flags the break, then receives the next byte normally.
// - Master, clocked mode and port enable select sync master pins.
// - Sync mode is half duplex.
// - Sync master drives the serial clock.
// - Polarity bits set idle levels of clock and data lines.
// - Data is sampled as the clock returns to idle.
// - Buffer to shifter move in one cycle sets buffer empty flag.
`timescale 1ns/1ps
`include "eus_map.svh"
module eus_top (
    input  wire logic       CORE_CLK,
    input  wire logic       NRST,
    input  wire logic [2:0] REG_ADDR,
    input  wire logic [7:0] REG_WDATA,
    input  wire logic       REG_WR,
    input  wire logic       REG_RD,
    output logic      [7:0] REG_RDATA,
    input  wire logic       SLEEP,
    input  wire logic       SER_DAT_I,
    output logic            SER_DAT_O,
    output logic            SER_DAT_OE_N,
    output logic            SER_CLK_O,
    output logic            SER_CLK_OE_N,
    output logic            RX_FLAG,
    output logic            TX_FLAG
);
    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    logic               pen_ff, r9_ff, srx_ff, crx_ff, adr_ff, ferr_ff, oerr_ff, r9d_ff;
    logic               mst_ff, t9_ff, ten_ff, syn_ff, brk_ff, hsb_ff, t9d_ff;
    logic               rinv_ff, tinv_ff, wide_ff, wake_ff, abd_ff, wseen_ff;
    logic [7:0]         dvh_ff, dvl_ff, rxb_ff, txb_ff, rdata_ff;
    logic               rxf_ff, txf_ff, full_ff;
    logic [2:0]         rxs_ff;
    logic               rx_f_ff, rx_prev_ff;
    eus_pkg::eus_tx_st_t tx_st_ff;
    eus_pkg::eus_rx_st_t rx_st_ff;
    logic [13:0]        tsr_ff;
    logic [3:0]         left_ff, ridx_ff;
    logic               phase_ff, brk_act_ff, srun_ff;
    logic [15:0]        tcnt_ff, rcnt_ff;
    logic [8:0]         rsh_ff;
    eus_pkg::eus_pins_t pins_ff;

    logic [15:0] div;
    logic        run, sync_m, wr_rsc, wr_tsc, wr_bdc, wr_txb, rd_rxb;
    logic        rx_lvl, fall, rise, tx_tick, tx_load, srx_go, sync_sample;
    logic        a_done, s_done, dlv, keep, nxt_full, nxt_ten, brk_done;
    logic [3:0]  nbits;

    assign div     = wide_ff ? {dvh_ff, dvl_ff} : {8'h00, dvl_ff};
    assign run     = !SLEEP;
    assign sync_m  = syn_ff && mst_ff && pen_ff;
    assign wr_rsc  = REG_WR && REG_ADDR == `EUS_A_RSC;
    assign wr_tsc  = REG_WR && REG_ADDR == `EUS_A_TSC;
    assign wr_bdc  = REG_WR && REG_ADDR == `EUS_A_BDC;
    assign wr_txb  = REG_WR && REG_ADDR == `EUS_A_TXB;
    assign rd_rxb  = REG_RD && REG_ADDR == `EUS_A_RXB;
    assign nbits   = r9_ff ? 4'h9 : 4'h8;
    assign rx_lvl  = rx_f_ff ^ rinv_ff;
    assign fall    = rx_prev_ff && !rx_lvl;
    assign rise    = !rx_prev_ff && rx_lvl;
    assign tx_tick = run && tcnt_ff == div;
    assign tx_load = run && pen_ff && ten_ff && full_ff && tx_st_ff == eus_pkg::T_IDLE
                     && (!syn_ff || sync_m);
    assign srx_go  = run && sync_m && (srx_ff || crx_ff) && !tx_load
                     && tx_st_ff == eus_pkg::T_IDLE;
    assign sync_sample = tx_st_ff == eus_pkg::T_SYNC && srun_ff && tx_tick && !phase_ff;
    assign a_done  = rx_st_ff == eus_pkg::R_DATA && run && rcnt_ff == div && ridx_ff == nbits;
    assign s_done  = tx_st_ff == eus_pkg::T_SYNC && srun_ff && tx_tick && phase_ff && left_ff == 4'h1;
    assign dlv     = a_done || s_done;
    assign keep    = !(adr_ff && r9_ff && !rsh_ff[8]);
    assign nxt_full = wr_txb || (full_ff && !tx_load);
    assign nxt_ten  = wr_tsc ? REG_WDATA[`EUS_TSC_TEN] : ten_ff;
    assign brk_done = tx_st_ff == eus_pkg::T_ASYNC && tx_tick && left_ff == 4'h1 && brk_act_ff;

    // Receive pin synchroniser, change taken when stages two and three agree
    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            rxs_ff     <= 3'h7;
            rx_f_ff    <= 1'b1;
            rx_prev_ff <= 1'b1;
        end else begin
            rxs_ff <= {rxs_ff[1:0], SER_DAT_I};
            if (rxs_ff[1] == rxs_ff[2]) begin
                rx_f_ff <= rxs_ff[2];
            end
            rx_prev_ff <= rx_lvl;
        end
    end

    // ------------------------------------------------------------
    // Software registers
    // ------------------------------------------------------------
    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            {pen_ff, r9_ff, srx_ff, crx_ff, adr_ff} <= 5'h00;
            {mst_ff, t9_ff, ten_ff, syn_ff, brk_ff, hsb_ff, t9d_ff} <= 7'h00;
            {rinv_ff, tinv_ff, wide_ff, wake_ff, abd_ff} <= 5'h00;
            dvh_ff <= `EUS_RST_BYTE;
            dvl_ff <= `EUS_RST_BYTE;
        end else begin
            if (brk_done) begin
                brk_ff <= 1'b0;
            end
            if (wake_ff && wseen_ff && rise) begin
                wake_ff <= 1'b0;
            end
            if (s_done && !crx_ff) begin
                srx_ff <= 1'b0;  // Single word done
            end
            if (wr_rsc) begin
                pen_ff <= REG_WDATA[`EUS_RSC_PEN];
                r9_ff  <= REG_WDATA[`EUS_RSC_R9];
                srx_ff <= REG_WDATA[`EUS_RSC_SRX];
                crx_ff <= REG_WDATA[`EUS_RSC_CRX];
                adr_ff <= REG_WDATA[`EUS_RSC_ADR];
            end
            if (wr_tsc) begin
                mst_ff <= REG_WDATA[`EUS_TSC_MST];
                t9_ff  <= REG_WDATA[`EUS_TSC_T9];
                ten_ff <= REG_WDATA[`EUS_TSC_TEN];
                syn_ff <= REG_WDATA[`EUS_TSC_SYN];
                brk_ff <= REG_WDATA[`EUS_TSC_BRK];
                hsb_ff <= REG_WDATA[`EUS_TSC_HSB];
                t9d_ff <= REG_WDATA[`EUS_TSC_T9D];
            end
            if (wr_bdc) begin
                rinv_ff <= REG_WDATA[`EUS_BDC_RINV];
                tinv_ff <= REG_WDATA[`EUS_BDC_TINV];
                wide_ff <= REG_WDATA[`EUS_BDC_WIDE];
                wake_ff <= REG_WDATA[`EUS_BDC_WAKE];
                abd_ff  <= REG_WDATA[`EUS_BDC_ABD];
            end
            if (REG_WR && REG_ADDR == `EUS_A_DVH) begin
                dvh_ff <= REG_WDATA;
            end
            if (REG_WR && REG_ADDR == `EUS_A_DVL) begin
                dvl_ff <= REG_WDATA;
            end
        end
    end

    // Transmit buffer and its empty flag
    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            full_ff <= 1'b0;
            txb_ff  <= `EUS_RST_BYTE;
            txf_ff  <= 1'b0;
        end else begin
            full_ff <= nxt_full;
            if (wr_txb) begin
                txb_ff <= REG_WDATA;
            end
            txf_ff <= nxt_ten && !nxt_full;
        end
    end

    // ------------------------------------------------------------
    // Transmit and sync engine
    // ------------------------------------------------------------
    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            tcnt_ff <= 16'h0000;
        end else if (tx_st_ff == eus_pkg::T_IDLE || tx_tick) begin
            tcnt_ff <= 16'h0000;
        end else if (run) begin
            tcnt_ff <= tcnt_ff + 16'h0001;
        end
    end

    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            tx_st_ff   <= eus_pkg::T_IDLE;
            tsr_ff     <= 14'h3fff;
            left_ff    <= 4'h0;
            phase_ff   <= 1'b0;
            brk_act_ff <= 1'b0;
            srun_ff    <= 1'b0;
        end else begin
            unique case (tx_st_ff)
                eus_pkg::T_IDLE: begin
                    phase_ff <= 1'b0;
                    if (tx_load) begin
                        srun_ff <= 1'b0;
                        if (syn_ff) begin
                            tx_st_ff   <= eus_pkg::T_SYNC;
                            tsr_ff     <= {5'h1f, t9d_ff, txb_ff};
                            left_ff    <= nbits;
                            brk_act_ff <= 1'b0;
                        end else if (brk_ff) begin
                            tx_st_ff   <= eus_pkg::T_ASYNC;
                            tsr_ff     <= `EUS_BRK_FRAME;
                            left_ff    <= `EUS_BRK_BITS;
                            brk_act_ff <= 1'b1;
                        end else begin
                            tx_st_ff   <= eus_pkg::T_ASYNC;
                            tsr_ff     <= t9_ff ? {4'hf, t9d_ff, txb_ff, 1'b0} : {5'h1f, txb_ff, 1'b0};
                            left_ff    <= t9_ff ? 4'hb : 4'ha;
                            brk_act_ff <= 1'b0;
                        end
                    end else if (srx_go) begin
                        tx_st_ff <= eus_pkg::T_SYNC;
                        srun_ff  <= 1'b1;
                        left_ff  <= nbits;
                    end
                end
                eus_pkg::T_ASYNC: begin
                    if (tx_tick) begin
                        tsr_ff  <= {1'b1, tsr_ff[13:1]};
                        left_ff <= left_ff - 4'h1;
                        if (left_ff == 4'h1) begin
                            tx_st_ff   <= eus_pkg::T_IDLE;
                            brk_act_ff <= 1'b0;
                        end
                    end
                end
                eus_pkg::T_SYNC: begin
                    if (tx_tick) begin
                        phase_ff <= !phase_ff;
                        if (phase_ff) begin
                            tsr_ff  <= {1'b1, tsr_ff[13:1]};
                            left_ff <= left_ff - 4'h1;
                            if (left_ff == 4'h1) begin
                                tx_st_ff <= eus_pkg::T_IDLE;
                            end
                        end
                    end
                end
            endcase
        end
    end

    // Pin drive, clock and data idle levels follow polarity bits
    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            pins_ff <= 4'hf;
        end else begin
            pins_ff.clk_oe_n <= !pen_ff || (syn_ff && !mst_ff);
            pins_ff.dat_oe_n <= !(sync_m && !srx_ff && !crx_ff && !srun_ff);
            pins_ff.dat_o    <= (tx_st_ff == eus_pkg::T_SYNC) ? tsr_ff[0] ^ rinv_ff : rinv_ff;
            unique case (tx_st_ff)
                eus_pkg::T_ASYNC: pins_ff.clk_o <= tsr_ff[0] ^ tinv_ff;
                eus_pkg::T_SYNC:  pins_ff.clk_o <= phase_ff ? tinv_ff : !tinv_ff;
                eus_pkg::T_IDLE:  pins_ff.clk_o <= syn_ff ? tinv_ff : !tinv_ff;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Receiver, wake detect and receive flag
    // ------------------------------------------------------------
    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            rx_st_ff <= eus_pkg::R_IDLE;
            rcnt_ff  <= 16'h0000;
            ridx_ff  <= 4'h0;
        end else if (wake_ff || syn_ff || !pen_ff || !crx_ff) begin
            rx_st_ff <= eus_pkg::R_IDLE;
            rcnt_ff  <= 16'h0000;
        end else if (run) begin
            unique case (rx_st_ff)
                eus_pkg::R_IDLE: begin
                    rcnt_ff <= 16'h0000;
                    if (fall) begin
                        rx_st_ff <= eus_pkg::R_START;
                    end
                end
                eus_pkg::R_START: begin
                    rcnt_ff <= rcnt_ff + 16'h0001;
                    if (rcnt_ff == {1'b0, div[15:1]}) begin
                        rx_st_ff <= rx_lvl ? eus_pkg::R_IDLE : eus_pkg::R_DATA;
                        rcnt_ff  <= 16'h0000;
                        ridx_ff  <= 4'h0;
                    end
                end
                eus_pkg::R_DATA: begin
                    rcnt_ff <= rcnt_ff + 16'h0001;
                    if (rcnt_ff == div) begin
                        rcnt_ff <= 16'h0000;
                        ridx_ff <= ridx_ff + 4'h1;
                        if (ridx_ff == nbits) begin
                            rx_st_ff <= eus_pkg::R_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // Shift in data bits from the async or sync receive path
    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            rsh_ff <= 9'h000;
        end else if (sync_sample || (rx_st_ff == eus_pkg::R_DATA && run && rcnt_ff == div && ridx_ff != nbits)) begin
            rsh_ff <= {rx_lvl, rsh_ff[8:1]};
        end
    end

    // Buffer load, errors, wake event and flag; set wins over read clear
    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            rxb_ff   <= `EUS_RST_BYTE;
            rxf_ff   <= 1'b0;
            ferr_ff  <= 1'b0;
            oerr_ff  <= 1'b0;
            r9d_ff   <= 1'b0;
            wseen_ff <= 1'b0;
        end else begin
            if (!crx_ff) begin
                oerr_ff <= 1'b0;
            end
            if (rd_rxb) begin
                rxf_ff <= 1'b0;
            end
            if (!wake_ff || rise) begin
                wseen_ff <= 1'b0;
            end
            if (wake_ff && !wseen_ff && fall) begin
                wseen_ff <= 1'b1;
                rxf_ff   <= 1'b1;
            end
            if (dlv && keep) begin
                if (rxf_ff && !rd_rxb) begin
                    oerr_ff <= 1'b1;
                end else begin
                    rxb_ff  <= r9_ff ? rsh_ff[7:0] : rsh_ff[8:1];
                    r9d_ff  <= rsh_ff[8];
                    ferr_ff <= a_done && !rx_lvl;
                    rxf_ff  <= 1'b1;
                end
            end
        end
    end

    // Read data, one cycle after the strobe, zero otherwise
    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            rdata_ff <= 8'h00;
        end else if (REG_RD) begin
            unique case (REG_ADDR)
                `EUS_A_RSC: rdata_ff <= {pen_ff, r9_ff, srx_ff, crx_ff, adr_ff, ferr_ff, oerr_ff, r9d_ff};
                `EUS_A_RXB: rdata_ff <= rxb_ff;
                `EUS_A_TSC: rdata_ff <= {mst_ff, t9_ff, ten_ff, syn_ff, brk_ff, hsb_ff,
                                         tx_st_ff == eus_pkg::T_IDLE, t9d_ff};
                `EUS_A_BDC: rdata_ff <= {1'b0, rx_st_ff == eus_pkg::R_IDLE, rinv_ff, tinv_ff,
                                         wide_ff, 1'b0, wake_ff, abd_ff};
                `EUS_A_DVH: rdata_ff <= dvh_ff;
                `EUS_A_DVL: rdata_ff <= dvl_ff;
                `EUS_A_FLG: rdata_ff <= {6'h00, txf_ff, rxf_ff};
                default:    rdata_ff <= 8'h00;
            endcase
        end else begin
            rdata_ff <= 8'h00;
        end
    end

    assign REG_RDATA    = rdata_ff;
    assign RX_FLAG      = rxf_ff;
    assign TX_FLAG      = txf_ff;
    assign SER_CLK_O    = pins_ff.clk_o;
    assign SER_CLK_OE_N = pins_ff.clk_oe_n;
    assign SER_DAT_O    = pins_ff.dat_o;
    assign SER_DAT_OE_N = pins_ff.dat_oe_n;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!NRST);

    sequence s_brk_load;
        tx_load && brk_ff && !syn_ff;
    endsequence
    sequence s_brk_frame;
        tsr_ff[12:0] == 13'h0000 && tsr_ff[13] && left_ff == `EUS_BRK_BITS && tx_st_ff == eus_pkg::T_ASYNC;
    endsequence

    chk_addr_filter: assert property (dlv && !keep && !rd_rxb |=> $stable(rxb_ff) && $stable(rxf_ff))
        else $error("address frame without ninth bit was kept");
    chk_sleep_hold: assert property (SLEEP |=> $stable(tx_st_ff) && $stable(rx_st_ff))
        else $error("serial state moved during sleep");
    chk_wake_idle: assert property (wake_ff |=> rx_st_ff == eus_pkg::R_IDLE)
        else $error("receiver left idle with wake enabled");
    chk_wake_flag: assert property (wake_ff && !wseen_ff && fall |=> rxf_ff && wseen_ff)
        else $error("wake edge did not set receive flag");
    chk_read_clear: assert property (rd_rxb && !dlv && !(wake_ff && fall) |=> !RX_FLAG)
        else $error("buffer read did not clear flag");
    chk_wake_clear: assert property (wake_ff && wseen_ff && rise && !wr_bdc |=> !wake_ff)
        else $error("wake enable not cleared on rising edge");
    chk_break_frame: assert property (s_brk_load |=> s_brk_frame)
        else $error("break frame not loaded as zeros");
    chk_break_done: assert property (brk_done && !wr_tsc |=> !brk_ff ##1 (!brk_ff || $past(wr_tsc)))
        else $error("break request not cleared after stop bit");
    chk_shift_register_empty_view: assert property (REG_RD && REG_ADDR == `EUS_A_TSC |=> REG_RDATA[1] == $past(tx_st_ff == eus_pkg::T_IDLE))
        else $error("shift register empty bit wrong");
    chk_half_duplex: assert property (tx_st_ff == eus_pkg::T_SYNC |-> rx_st_ff == eus_pkg::R_IDLE && !tx_load)
        else $error("sync transfer overlapped another");
    chk_clk_idle: assert property (tx_st_ff == eus_pkg::T_IDLE && syn_ff ##1 tx_st_ff == eus_pkg::T_IDLE |-> SER_CLK_O == $past(tinv_ff))
        else $error("sync clock not at idle level");
    chk_buf_flag: assert property (tx_load && !wr_txb && !wr_tsc |=> TX_FLAG && !full_ff)
        else $error("buffer empty flag not set on shifter load");
endmodule : eus_top

// ---- src/eus_map.svh ----
/*
 Register offsets, field positions, reset values and frame counts of the
 serial port. Assumes inclusion by bare name from the top and the bench.
*/
`ifndef EUS_MAP_SVH
`define EUS_MAP_SVH
// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define EUS_A_RSC   3'h0
`define EUS_A_RXB   3'h1
`define EUS_A_TSC   3'h2
`define EUS_A_BDC   3'h3
`define EUS_A_DVH   3'h4
`define EUS_A_DVL   3'h5
`define EUS_A_TXB   3'h6
`define EUS_A_FLG   3'h7
// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define EUS_RSC_PEN   7
`define EUS_RSC_R9    6
`define EUS_RSC_SRX   5
`define EUS_RSC_CRX   4
`define EUS_RSC_ADR   3
`define EUS_TSC_MST   7
`define EUS_TSC_T9    6
`define EUS_TSC_TEN   5
`define EUS_TSC_SYN   4
`define EUS_TSC_BRK   3
`define EUS_TSC_HSB   2
`define EUS_TSC_T9D   0
`define EUS_BDC_RINV  5
`define EUS_BDC_TINV  4
`define EUS_BDC_WIDE  3
`define EUS_BDC_WAKE  1
`define EUS_BDC_ABD   0
// ------------------------------------------------------------
// Reset values and frame counts
// ------------------------------------------------------------
`define EUS_RST_BYTE  8'h00
`define EUS_BRK_BITS  4'he
`define EUS_BRK_FRAME 14'h2000
`endif

// ---- src/eus_pkg.sv ----
/*
 Types shared by the serial port design.
 Assumes nothing beyond the constants header.
*/
package eus_pkg;
    // ------------------------------------------------------------
    // State types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {T_IDLE = 3'b001, T_ASYNC = 3'b010, T_SYNC = 3'b100} eus_tx_st_t;
    typedef enum logic [2:0] {R_IDLE = 3'b001, R_START = 3'b010, R_DATA = 3'b100} eus_rx_st_t;
    // Pin drive group
    typedef struct packed {
        logic clk_o;
        logic clk_oe_n;
        logic dat_o;
        logic dat_oe_n;
    } eus_pins_t;
endpackage : eus_pkg

// ---- verification/eus_node.sv ----
/*
 Remote serial node that drives the receive pin of the port.
 Assumes bit times are given in core clock cycles; the line idles high.
*/
`timescale 1ns/1ps
module eus_node (
    input  wire logic CLK,
    output logic      LINE
);
    initial LINE = 1'b1;
    // Level held on the line, for breaks and idle
    task automatic hold(input logic lvl);
        LINE <= lvl;
    endtask : hold
    // One frame: start, data LSB first, stop; a zero frame is the wake break
    task automatic send(input logic [8:0] d, input int nb, input int bt);
        LINE <= 1'b0;
        repeat (bt) @(posedge CLK);
        for (int i = 0; i < nb; i++) begin
            LINE <= d[i];
            repeat (bt) @(posedge CLK);
        end
        LINE <= 1'b1;
        repeat (bt) @(posedge CLK);
    endtask : send
endmodule : eus_node

// ---- verification/eus_top_tb_top.sv ----
/*
 Self-checking bench for the serial port extensions.
 Assumes the node model on the receive pin and a divisor of 3 (4 cycles a bit),
 raised to 12 only for the slowed break reception.
*/
`timescale 1ns/1ps
`include "eus_map.svh"
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_mismatch++; \
    $display("CHECK FAILED %0t got %h exp %h", $time, a, b); end end
module eus_top_tb_top;
    logic       CORE_CLK;
    logic       NRST      = 1'b0;
    logic [2:0] REG_ADDR  = 3'h0;
    logic [7:0] REG_WDATA = 8'h00;
    logic       REG_WR    = 1'b0;
    logic       REG_RD    = 1'b0;
    logic       SLEEP     = 1'b0;
    logic [7:0] REG_RDATA;
    logic       SER_DAT_I, SER_DAT_O, SER_DAT_OE_N, SER_CLK_O, SER_CLK_OE_N, RX_FLAG, TX_FLAG;
    int         n_mismatch = 0;
    int         n_checks   = 0;
    int         n_low      = 0;
    eus_top u_dut (.CORE_CLK(CORE_CLK), .NRST(NRST), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
        .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .SLEEP(SLEEP), .SER_DAT_I(SER_DAT_I),
        .SER_DAT_O(SER_DAT_O), .SER_DAT_OE_N(SER_DAT_OE_N), .SER_CLK_O(SER_CLK_O),
        .SER_CLK_OE_N(SER_CLK_OE_N), .RX_FLAG(RX_FLAG), .TX_FLAG(TX_FLAG));
    eus_node u_node (.CLK(CORE_CLK), .LINE(SER_DAT_I));
    // Core clock, 5 ns period
    initial begin
        CORE_CLK = 1'b0;
        forever #2.5 CORE_CLK = ~CORE_CLK;
    end
    // Low cycles on the transmit line
    always @(posedge CORE_CLK) if (SER_CLK_O === 1'b0) n_low <= n_low + 1;
    // Register bus write and read
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        REG_ADDR  <= a;
        REG_WDATA <= d;
        REG_WR    <= 1'b1;
        @(posedge CORE_CLK);
        REG_WR <= 1'b0;
        @(posedge CORE_CLK);
    endtask : wr
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        REG_ADDR <= a;
        REG_RD   <= 1'b1;
        @(posedge CORE_CLK);
        REG_RD <= 1'b0;
        #1 d = REG_RDATA;
        @(posedge CORE_CLK);
    endtask : rd
    // Frame from the node, then flag and buffer checks
    task automatic rx_frame(input logic [8:0] v, input int nb, input logic kept);
        logic [7:0] r;
        u_node.send(v, nb, 4);
        repeat (4) @(posedge CORE_CLK);
        `CHK(RX_FLAG, kept)
        if (kept) begin
            rd(`EUS_A_RXB, r);
            `CHK(r, v[7:0])
            `CHK(RX_FLAG, 1'b0)
            @(posedge CORE_CLK);
        end
    endtask : rx_frame
    task automatic wrap_up;
        if (n_mismatch == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : wrap_up
    // Main sequence
    initial begin
        int         i, n_base;
        logic [7:0] d, r;
        void'($urandom(18234));
        repeat (2) @(posedge CORE_CLK);
        NRST <= 1'b1;
        @(posedge CORE_CLK);
        wr(`EUS_A_FLG, 8'hff);
        rd(`EUS_A_FLG, r);
        `CHK(r, 8'h00)
        d = 8'($urandom);
        wr(`EUS_A_DVH, d);
        rd(`EUS_A_DVH, r);
        `CHK(r, d)
        wr(`EUS_A_DVH, 8'h00);
        wr(`EUS_A_DVL, 8'h03);
        wr(`EUS_A_RSC, 8'h80);
        wr(`EUS_A_TSC, 8'h28);
        n_base = n_low;
        wr(`EUS_A_TXB, 8'($urandom) | 8'h01);
        wr(`EUS_A_TXB, 8'h55);
        repeat (8) @(posedge CORE_CLK);
        rd(`EUS_A_TSC, r);
        `CHK(r[1], 1'b0)
        repeat (150) @(posedge CORE_CLK);
        `CHK(n_low - n_base, 72)
        rd(`EUS_A_TSC, r);
        `CHK(r[3], 1'b0)
        `CHK(r[1], 1'b1)
        `CHK(TX_FLAG, 1'b1)
        wr(`EUS_A_TSC, 8'h00);
        wr(`EUS_A_RSC, 8'hd8);
        d = 8'($urandom);
        rx_frame({1'b0, d}, 9, 1'b0);
        rx_frame({1'b1, d}, 9, 1'b1);
        wr(`EUS_A_RSC, 8'hd0);
        rx_frame({1'b0, ~d}, 9, 1'b1);
        wr(`EUS_A_RSC, 8'h90);
        rd(`EUS_A_BDC, r);
        `CHK(r[6], 1'b1)
        wr(`EUS_A_BDC, 8'h02);
        SLEEP <= 1'b1;
        u_node.hold(1'b0);
        repeat (52) @(posedge CORE_CLK);
        `CHK(RX_FLAG, 1'b1)
        SLEEP <= 1'b0;
        rd(`EUS_A_RXB, r);
        `CHK(RX_FLAG, 1'b0)
        u_node.hold(1'b1);
        repeat (8) @(posedge CORE_CLK);
        rd(`EUS_A_BDC, r);
        `CHK(r[1], 1'b0)
        rx_frame({1'b0, 8'($urandom)}, 8, 1'b1);
        // Break of 13 low bits of 9 cycles, received at 13 cycles a bit
        wr(`EUS_A_DVL, 8'h0c);
        u_node.hold(1'b0);
        repeat (117) @(posedge CORE_CLK);
        u_node.hold(1'b1);
        repeat (13) @(posedge CORE_CLK);
        `CHK(RX_FLAG, 1'b1)
        rd(`EUS_A_RXB, r);
        `CHK(r, 8'h00)
        wr(`EUS_A_DVL, 8'h03);
        wr(`EUS_A_RSC, 8'h80);
        wr(`EUS_A_TSC, 8'h90);
        for (i = 0; i < 4; i++) begin
            wr(`EUS_A_BDC, 8'(i << 4));
            repeat (4) @(posedge CORE_CLK);
            `CHK(SER_CLK_O, i[0])
            `CHK(SER_DAT_O, i[1])
            `CHK(SER_CLK_OE_N, 1'b0)
            `CHK(SER_DAT_OE_N, 1'b0)
        end
        // Single sync master receive of a low data line, inverted
        u_node.hold(1'b0);
        wr(`EUS_A_RSC, 8'ha0);
        repeat (20) @(posedge CORE_CLK);
        `CHK(SER_DAT_OE_N, 1'b1)
        repeat (60) @(posedge CORE_CLK);
        `CHK(RX_FLAG, 1'b1)
        rd(`EUS_A_RXB, r);
        `CHK(r, 8'hff)
        wrap_up();
    end
endmodule : eus_top_tb_top
